// ===== common/beam_cfg_regs.svh
// register offsets, field positions, reset values and timing counts of the global configuration
`ifndef BEAM_CFG_REGS_SVH
`define BEAM_CFG_REGS_SVH
`define ADDR_BITS 5
`define ADDR_TOP_CONTROL 5'h1A
`define ADDR_REF_CLOCK_SELECT 5'h1B
`define TOP_CONTROL_BITS 14
`define REF_CLOCK_SELECT_BITS 8
`define TOP_CONTROL_RESET 14'h047F
`define REF_CLOCK_SELECT_RESET 8'h00
`define SYNC_RESET 5'h04
`define HIST_RESET 3'h2
`define POS_CW 12
`define POS_INVERT 11
`define POS_LOOP_EN 10
`define POS_DIV_HI 9
`define POS_DIV_LO 3
`define POS_LEN_HI 2
`define POS_LEN_LO 0
`define POS_REF_KIND 0
`define DIV_ZERO_HOLD 8'h80
`define MASTER_CLOCK_MHZ 160
`define TRIGGER_LEAD_CYCLES 6
`define TRIGGER_LEAD_COUNT 3'h5
`define PATTERN_BITS 64
`endif

// ===== common/beam_cfg_pkg.sv
// types shared by the beamformer global configuration block
package beam_cfg_pkg;
    typedef struct packed {
        logic cw;
        logic invert;
        logic loop_en;
        logic [6:0] divider;
        logic [2:0] length_code;
    } top_fields_t;
    typedef struct packed {
        logic p;
        logic n;
    } pulse_pair_t;
    typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_EMIT, ST_WAIT_RX} fire_state_t;
endpackage : beam_cfg_pkg

// ===== rtl/beamformer_global_config.sv
// global configuration registers and firing sequencer of the transmit beamformer
// Notes on behaviour
// - With invert-fire off each transmission sends the pattern once, unchanged.
// - With invert-fire on a transmission sends the pattern, then, if serial latch enable stays high until receive completes, sends it inverted.
// - Control bit 10 enables the on-chip loop (0 off, 1 on).
// - The seven-bit divider in bits 9:3 holds each pattern bit for that many master-clock cycles.
// - A divider of zero gives the maximum division of 128, that is 128 cycles per bit.
// - The length code selects 4, 8, 16, 24, 32, 40, 48 or 64 pattern bits for all channels.
// - Bit 0 of the reference select register picks differential (0) or single-ended (1) reference.
// - Outside continuous wave each firing stops after one pattern, or after the pattern and its inverse with invert-fire on, and waits for the next trigger rise.
// - Emission starts 10 master-clock cycles after the trigger pin rises, least significant bit first.
`timescale 1ns/1ps
`include "beam_cfg_regs.svh"
module beamformer_global_config
    import beam_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic serial_latch_enable,
    input wire logic fire_trigger,
    input wire logic rx_done,
    input wire logic [63:0] pattern_p,
    input wire logic [63:0] pattern_n,
    output logic loop_enable_bit,
    output logic ref_clock_kind,
    output logic continuous_wave_select,
    output logic [13:0] top_control,
    output logic [7:0] reference_clock_select,
    output pulse_pair_t pulse_out,
    output logic firing
);
    // two-flop synchronisers for the five serial, trigger and rx_done pins; stage 1 feeds stage 2 only
    logic [4:0] sync1_ff;
    logic [4:0] sync2_ff;
    logic [4:0] nxt_sync1;
    logic [4:0] nxt_sync2;
    logic [2:0] hist_ff;
    logic [2:0] nxt_hist;
    logic s_clk;
    logic s_dat;
    logic s_le;
    logic s_fire;
    logic s_rx;
    always_comb
    begin
        nxt_sync1 = {serial_clock, serial_data, serial_latch_enable, fire_trigger, rx_done};
        nxt_sync2 = sync1_ff;
        nxt_hist = {s_clk, s_le, s_fire};
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1_ff <= `SYNC_RESET; // idle pin levels, so no false edge follows reset
            sync2_ff <= `SYNC_RESET;
            hist_ff <= `HIST_RESET;
        end
        else
        begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            hist_ff <= nxt_hist;
        end
    end
    assign {s_clk, s_dat, s_le, s_fire, s_rx} = sync2_ff;

    // serial frame: latch low opens it, address then data, lsb first, latch rise commits
    logic [7:0] count_ff;
    logic [7:0] nxt_count;
    logic [4:0] addr_ff;
    logic [4:0] nxt_addr;
    logic [13:0] shift_ff;
    logic [13:0] nxt_shift;
    logic [13:0] top_ff;
    logic [13:0] nxt_top;
    logic [7:0] ref_ff;
    logic [7:0] nxt_ref;
    logic clk_rise;
    logic le_rise;
    logic [7:0] data_idx;
    always_comb
    begin
        clk_rise = s_clk && !hist_ff[2];
        le_rise = s_le && !hist_ff[1];
        data_idx = count_ff - 8'(`ADDR_BITS);
        nxt_count = count_ff;
        nxt_addr = addr_ff;
        nxt_shift = shift_ff;
        nxt_top = top_ff;
        nxt_ref = ref_ff;
        if (!s_le && clk_rise)
        begin
            if (count_ff < 8'(`ADDR_BITS))
            begin
                nxt_addr[count_ff[2:0]] = s_dat;
            end
            else if (data_idx < 8'(`TOP_CONTROL_BITS))
            begin
                nxt_shift[data_idx[3:0]] = s_dat;
            end
            if (count_ff != 8'hFF)
            begin
                nxt_count = count_ff + 8'h01;
            end
        end
        if (le_rise)
        begin
            if (addr_ff == `ADDR_TOP_CONTROL && count_ff == 8'(`ADDR_BITS + `TOP_CONTROL_BITS))
            begin
                nxt_top = shift_ff;
            end
            if (addr_ff == `ADDR_REF_CLOCK_SELECT && count_ff == 8'(`ADDR_BITS + `REF_CLOCK_SELECT_BITS))
            begin
                nxt_ref = shift_ff[7:0];
            end
        end
        if (s_le)
        begin
            nxt_count = 8'h00;
        end
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            count_ff <= 8'h00;
            addr_ff <= 5'h00;
            shift_ff <= 14'h0000;
            top_ff <= `TOP_CONTROL_RESET;
            ref_ff <= `REF_CLOCK_SELECT_RESET;
        end
        else
        begin
            count_ff <= nxt_count;
            addr_ff <= nxt_addr;
            shift_ff <= nxt_shift;
            top_ff <= nxt_top;
            ref_ff <= nxt_ref;
        end
    end
    assign top_control = top_ff;
    assign reference_clock_select = ref_ff;
    assign loop_enable_bit = top_ff[`POS_LOOP_EN];
    assign ref_clock_kind = ref_ff[`POS_REF_KIND];
    assign continuous_wave_select = top_ff[`POS_CW];

    // pattern length code to bit count
    function automatic logic [6:0] length_of(input logic [2:0] code);
        logic [6:0] len;
        len = 7'h40;
        unique case (code)
            3'h0: len = 7'h04;
            3'h1: len = 7'h08;
            3'h2: len = 7'h10;
            3'h3: len = 7'h18;
            3'h4: len = 7'h20;
            3'h5: len = 7'h28;
            3'h6: len = 7'h30;
            3'h7: len = 7'h40;
        endcase
        return len;
    endfunction : length_of

    // firing sequencer
    fire_state_t state_ff;
    fire_state_t nxt_state;
    top_fields_t live_ff;
    top_fields_t nxt_live;
    logic [7:0] tick_ff;
    logic [7:0] nxt_tick;
    logic [6:0] bit_ff;
    logic [6:0] nxt_bit;
    logic inv_ff;
    logic nxt_inv;
    logic rx_ff;
    logic nxt_rx;
    pulse_pair_t out_ff;
    pulse_pair_t nxt_out;
    logic [7:0] hold;
    logic fire_rise;
    always_comb
    begin
        fire_rise = s_fire && !hist_ff[0];
        hold = (live_ff.divider == 7'h00) ? `DIV_ZERO_HOLD : {1'b0, live_ff.divider};
        nxt_state = state_ff;
        nxt_live = live_ff;
        nxt_tick = tick_ff;
        nxt_bit = bit_ff;
        nxt_inv = inv_ff;
        nxt_rx = s_rx;
        nxt_out = '0;
        unique case (state_ff)
            ST_IDLE:
            begin
                if (fire_rise && !top_ff[`POS_CW])
                begin
                    nxt_live = top_fields_t'(top_ff[`POS_CW:`POS_LEN_LO]);
                    nxt_state = ST_LEAD;
                    nxt_tick = 8'h00;
                    nxt_inv = 1'b0;
                end
            end
            ST_LEAD:
            begin
                nxt_tick = tick_ff + 8'h01;
                if (tick_ff[2:0] == `TRIGGER_LEAD_COUNT)
                begin
                    nxt_state = ST_EMIT;
                    nxt_tick = 8'h00;
                    nxt_bit = 7'h00;
                end
            end
            ST_EMIT:
            begin
                nxt_out.p = pattern_p[bit_ff[5:0]] ^ inv_ff;
                nxt_out.n = pattern_n[bit_ff[5:0]] ^ inv_ff;
                nxt_tick = tick_ff + 8'h01;
                if (tick_ff == hold - 8'h01)
                begin
                    nxt_tick = 8'h00;
                    nxt_bit = bit_ff + 7'h01;
                    if (bit_ff == length_of(live_ff.length_code) - 7'h01)
                    begin
                        nxt_state = (live_ff.invert && !inv_ff) ? ST_WAIT_RX : ST_IDLE;
                    end
                end
            end
            ST_WAIT_RX:
            begin
                if (!s_le)
                begin
                    nxt_state = ST_IDLE;
                end
                else if (s_rx && !rx_ff)
                begin
                    nxt_inv = 1'b1;
                    nxt_state = ST_EMIT;
                    nxt_tick = 8'h00;
                    nxt_bit = 7'h00;
                end
            end
        endcase
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff <= ST_IDLE;
            live_ff <= '0;
            tick_ff <= 8'h00;
            bit_ff <= 7'h00;
            inv_ff <= 1'b0;
            rx_ff <= 1'b0;
            out_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            live_ff <= nxt_live;
            tick_ff <= nxt_tick;
            bit_ff <= nxt_bit;
            inv_ff <= nxt_inv;
            rx_ff <= nxt_rx;
            out_ff <= nxt_out;
        end
    end
    assign pulse_out = out_ff;
    assign firing = (state_ff != ST_IDLE);
endmodule : beamformer_global_config

// ===== verification/serial_host_model.sv
// host controller model driving the serial configuration pins
`timescale 1ns/1ps
module serial_host_model
(
    input wire logic clk,
    output logic serial_clock,
    output logic serial_data,
    output logic serial_latch_enable
);
    initial
    begin
        serial_clock = 1'b0;
        serial_data = 1'b0;
        serial_latch_enable = 1'b1;
    end

    // one frame, address then data lsb first, each clock phase held ph cycles
    task automatic send(input logic [18:0] bits, input int n, input int ph);
        if (bits[4:0] == 5'h1B)
            bits[12:6] = 7'h00;
        else
            bits[18] = 1'b0;
        @(posedge clk);
        serial_latch_enable <= 1'b0;
        for (int i = 0; i < n; i++)
        begin
            serial_data <= bits[i];
            repeat (ph) @(posedge clk);
            serial_clock <= 1'b1;
            repeat (ph) @(posedge clk);
            serial_clock <= 1'b0;
        end
        repeat (ph) @(posedge clk);
        serial_latch_enable <= 1'b1;
        serial_data <= ~serial_data;
        repeat (4) @(posedge clk);
    endtask : send
endmodule : serial_host_model

// ===== verification/beamformer_global_config_checker.sv
// concurrent checks on the global configuration block ports
`timescale 1ns/1ps
module beamformer_global_config_checker
    import beam_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic fire_trigger,
    input wire logic loop_enable_bit,
    input wire logic ref_clock_kind,
    input wire logic continuous_wave_select,
    input wire logic [13:0] top_control,
    input wire logic [7:0] reference_clock_select,
    input wire pulse_pair_t pulse_out,
    input wire logic firing
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);

    chk_loop_bit: assert property (loop_enable_bit == top_control[10])
        else $error("loop enable output differs from control bit");
    chk_ref_kind: assert property (ref_clock_kind == reference_clock_select[0])
        else $error("reference kind output differs from select bit");
    chk_cw_bit: assert property (continuous_wave_select == top_control[12])
        else $error("continuous wave output differs from control bit");
    chk_idle_quiet: assert property (!firing && !$past(firing) |-> pulse_out == 2'h0)
        else $error("pulse while idle");
    chk_fire_start: assert property ($rose(fire_trigger) && !firing && !continuous_wave_select |-> ##[1:5] firing)
        else $error("trigger rise did not start a firing");
    chk_lead_quiet: assert property ($rose(firing) |-> (pulse_out == 2'h0) [*6])
        else $error("pulse during lead cycles");
    chk_cw_refuse: assert property (continuous_wave_select && !firing |=> !firing)
        else $error("firing started in continuous wave mode");
    chk_rise_cause: assert property ($rose(firing) |-> $past(fire_trigger, 2))
        else $error("firing started without trigger");
endmodule : beamformer_global_config_checker

bind beamformer_global_config beamformer_global_config_checker u_chk (.clk, .resetn, .fire_trigger,
    .loop_enable_bit, .ref_clock_kind, .continuous_wave_select, .top_control, .reference_clock_select,
    .pulse_out, .firing);

// ===== verification/beamformer_global_config_tb.sv
// self-checking bench for the beamformer global configuration block
`timescale 1ns/1ps
`include "beam_cfg_regs.svh"
module beamformer_global_config_tb;
    import beam_cfg_pkg::*;
    logic clk, resetn, serial_clock, serial_data, serial_latch_enable, fire_trigger, rx_done;
    logic loop_enable_bit, ref_clock_kind, continuous_wave_select, firing;
    logic [63:0] pattern_p, pattern_n;
    logic [13:0] top_control;
    logic [7:0] reference_clock_select;
    pulse_pair_t pulse_out;
    pulse_pair_t exp_q[$];
    int lens[8] = '{4, 8, 16, 24, 32, 40, 48, 64};
    int n_mismatch = 0;
    int checks_done = 0;
    logic [13:0] tc;

    beamformer_global_config dut (.clk, .resetn, .serial_clock, .serial_data, .serial_latch_enable,
        .fire_trigger, .rx_done, .pattern_p, .pattern_n, .loop_enable_bit, .ref_clock_kind,
        .continuous_wave_select, .top_control, .reference_clock_select, .pulse_out, .firing);
    serial_host_model host (.clk, .serial_clock, .serial_data, .serial_latch_enable);

    task automatic chk(input string what, input logic [13:0] e, input logic [13:0] s);
        checks_done++;
        if (e !== s)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [4:0] a, input logic [13:0] d, input int ph);
        host.send({d, a}, (a == 5'h1B) ? 13 : 19, ph);
        repeat (3) @(posedge clk);
    endtask : wr

    task automatic wait_q(input int n);
        for (int k = 0; k < 3000 && exp_q.size() > n; k++)
            @(posedge clk);
    endtask : wait_q

    // notes every expected pulse pair, then fires once
    task automatic fire(input logic [13:0] c);
        int d;
        int len;
        logic [63:0] p;
        d = (c[9:3] == 7'h00) ? 128 : int'(c[9:3]);
        len = lens[c[2:0]];
        p = {$urandom, $urandom};
        pattern_p <= p;
        pattern_n <= ~p;
        for (int k = 0; k < 2 * len; k++)
            if (k < len || c[11])
                repeat (d) exp_q.push_back(k < len ? {p[k], ~p[k]} : {~p[k - len], p[k - len]});
        @(posedge clk);
        fire_trigger <= 1'b1;
        wait_q(c[11] ? len * d : 0);
        if (c[11])
        begin
            repeat (10) @(posedge clk);
            chk("held_back", 14'(len * d), 14'(exp_q.size()));
            rx_done <= 1'b1;
            wait_q(0);
        end
        repeat (20) @(posedge clk);
        rx_done <= 1'b1;
        repeat (10) @(posedge clk);
        chk("firing", 14'h0, 14'(firing));
        chk("left", 14'h0, 14'(exp_q.size()));
        fire_trigger <= 1'b0;
        rx_done <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : fire

    // takes the oldest note whenever a pulse is on the outputs
    always @(negedge clk)
        if (pulse_out !== 2'h0)
            chk("pulse_out", exp_q.size() ? 14'(exp_q.pop_front()) : 14'h0, 14'(pulse_out));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // watchdog cuts a hung run short
    initial
    begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end

    initial
    begin
        void'($urandom(32'h2e71));
        resetn = 1'b0;
        fire_trigger = 1'b0;
        rx_done = 1'b0;
        pattern_p = '0;
        pattern_n = '0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        chk("top_control", `TOP_CONTROL_RESET, top_control);
        chk("ref_select", 14'h0, 14'(reference_clock_select));
        // every length code, both invert settings, divider boundaries
        for (int i = 0; i < 10; i++)
        begin
            tc = {2'b00, i[0], i[1], 7'(1 + $urandom_range(2)), i[2:0]};
            if (i == 8)
                tc[9:3] = 7'h00;
            if (i == 9)
                tc[9:3] = 7'h7F;
            wr(5'h1A, tc, 3 + i % 3);
            chk("top_control", tc, top_control);
            fire(tc);
        end
        // a write landing in mid-firing must leave the running pattern alone
        wr(5'h1A, 14'h041F, 3);
        fork
            fire(14'h041F);
            begin
                repeat (20) @(posedge clk);
                wr(5'h1A, 14'h0408, 3);
            end
        join
        chk("top_control", 14'h0408, top_control);
        wr(5'h1A, 14'h1001, 3);
        fire_trigger <= 1'b1;
        repeat (12) @(posedge clk);
        chk("cw_firing", 14'h0, 14'(firing));
        fire_trigger <= 1'b0;
        wr(5'h1C, 14'h0155, 5);
        chk("top_control", 14'h1001, top_control);
        for (int v = 1; v >= 0; v--)
        begin
            wr(5'h1B, 14'(v), 5);
            chk("ref_select", 14'(v), 14'(reference_clock_select));
        end
        report_and_stop();
    end
endmodule : beamformer_global_config_tb
